// ===== core/crf_params.svh
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH
// ------------------------------------------------------------
// Address space and data area
// ------------------------------------------------------------
`define CRF_ADDR_W 20
`define CRF_AREA_LO 16'hf700
`define CRF_SFR_LO 16'hff00
`define CRF_RELOC_LOW 4'h0
`define CRF_RELOC_HIGH 4'hf
`define CRF_AREA_HI_RST 4'h0
`define CRF_SFR_MAP_DEF {{15{16'hffff}}, 16'hc0cf}
// ------------------------------------------------------------
// Register banks in internal RAM
// ------------------------------------------------------------
`define CRF_RAM_AW 10
`define CRF_BANK_WBASE 4'hf
`define CRF_ALIAS_BIT 5
`define CRF_LEGACY_R_BASE 2'b01
`define CRF_LEGACY_P_BASE 2'b01
`define CRF_ADDR_PAIR_BASE 1'b1
`define CRF_PC_RST 20'h00000
`endif

// ===== core/crf_pkg.sv
package crf_pkg;
  `include "crf_params.svh"

  typedef enum logic [1:0] {
    CRF_SZ_B8,
    CRF_SZ_W16,
    CRF_SZ_A24
  } crf_size_t;

  typedef struct packed {
    logic reloc_done;
    logic [3:0] area_hi;
    logic [2:0] bank;
    logic [`CRF_ADDR_W-1:0] pc;
    logic locked;
    logic [31:0][7:0] ext;
    logic reg_ack;
    logic reg_err;
    crf_size_t rsize;
    logic rhi;
    logic [7:0] ext_rd;
    logic mem_ack;
    logic mem_hi;
    logic mem_int;
    logic mem_sfr;
    logic mem_ram;
  } crf_state_t;
endpackage

// ===== core/crf_ram.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Dual-port internal RAM, 16-bit words with byte enables
// ------------------------------------------------------------
module crf_ram #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic [1:0] a_be,
  input wire logic [AW-1:0] a_addr,
  input wire logic [15:0] a_wdata,
  output logic [15:0] a_rdata,
  input wire logic [1:0] b_be,
  input wire logic [AW-1:0] b_addr,
  input wire logic [15:0] b_wdata,
  output logic [15:0] b_rdata
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Port a writes last, so it wins a same-byte collision
  always_ff @(posedge clk) begin
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
    for (int i = 0; i < 2; i++) begin
      if (b_be[i]) begin
        mem[b_addr][i*8 +: 8] <= b_wdata[i*8 +: 8];
      end
      if (a_be[i]) begin
        mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
      end
    end
  end
endmodule // crf_ram

// ===== core/crf_core.sv
// How it works
// - Every memory address and the program counter are 20 bits wide.
// - Operand 0 places the data area at 0F700H to 0FFFFH.
// - Operand 0FH places the data area at FF700H to FFFFFH.
// - Each bank holds sixteen byte registers addressable one by one.
// - Adjacent byte registers pair into eight 16-bit registers per bank.
// - Pairs four to seven join an extension byte as 24-bit addresses.
// - Eight banks exist, chosen by software or by a context switch.
// - All but the extension bytes live in internal RAM and alias it.
// - With the alias bit of the status word set, legacy names map.
// - The program counter is 20 bits and advances with execution.
// - Touching an unassigned SFR address locks the core until reset.
`timescale 1ns/1ns
`include "crf_params.svh"
module crf_core #(
  parameter logic [255:0] SFR_MAP = `CRF_SFR_MAP_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reloc_valid,
  input wire logic [3:0] data_area_relocate_op,
  input wire logic bank_sel_valid,
  input wire logic [2:0] bank_sel,
  input wire logic ctx_switch_valid,
  input wire logic [2:0] ctx_bank,
  input wire logic [15:0] processor_status_word,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire crf_pkg::crf_size_t reg_size,
  input wire logic reg_legacy,
  input wire logic [3:0] reg_idx,
  input wire logic [23:0] reg_wdata,
  output logic reg_ack,
  output logic reg_err,
  output logic [23:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [`CRF_ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic mem_int_hit,
  output logic mem_sfr_hit,
  input wire logic pc_load,
  input wire logic [`CRF_ADDR_W-1:0] pc_load_val,
  input wire logic [2:0] pc_step,
  output logic [`CRF_ADDR_W-1:0] pc,
  output logic [2:0] active_bank,
  output logic [3:0] area_high,
  output logic reloc_done,
  output logic core_locked
);
  crf_pkg::crf_state_t st_r;
  crf_pkg::crf_state_t st_nxt;
  logic [1:0] a_be;
  logic [9:0] a_addr;
  logic [15:0] a_wdata;
  logic [15:0] a_rdata;
  logic [1:0] b_be;
  logic [9:0] b_addr;
  logic [15:0] b_rdata;
  logic alias_on;
  logic reg_ok;
  logic [3:0] rbyte;
  logic [2:0] rpair;
  logic in_area;
  logic is_sfr;
  logic [15:0] ram_off;

  // ------------------------------------------------------------
  // Register and memory decode
  // ------------------------------------------------------------
  always_comb begin
    alias_on = processor_status_word[`CRF_ALIAS_BIT];
    reg_ok = reg_req && !st_r.locked &&
      !(reg_legacy && (!alias_on || reg_size == crf_pkg::CRF_SZ_A24));
    rbyte = reg_legacy ?
      {`CRF_LEGACY_R_BASE, reg_idx[1:0]} : reg_idx;
    case (reg_size)
      crf_pkg::CRF_SZ_B8: rpair = rbyte[3:1];
      crf_pkg::CRF_SZ_W16: begin
        rpair = reg_legacy ?
          {`CRF_LEGACY_P_BASE, reg_idx[0]} : reg_idx[2:0];
      end
      crf_pkg::CRF_SZ_A24: begin
        rpair = {`CRF_ADDR_PAIR_BASE, reg_idx[1:0]};
      end
      default: rpair = reg_idx[2:0];
    endcase
    a_addr = {`CRF_BANK_WBASE, st_r.bank, rpair};
    a_be = 2'b00;
    if (reg_ok && reg_we) begin
      if (reg_size == crf_pkg::CRF_SZ_B8) begin
        a_be = rbyte[0] ? 2'b10 : 2'b01;
      end else begin
        a_be = 2'b11;
      end
    end
    a_wdata = (reg_size == crf_pkg::CRF_SZ_B8) ?
      {reg_wdata[7:0], reg_wdata[7:0]} : reg_wdata[15:0];
    in_area = mem_addr[19:16] == st_r.area_hi &&
      mem_addr[15:0] >= `CRF_AREA_LO;
    is_sfr = in_area && mem_addr[15:0] >= `CRF_SFR_LO;
    ram_off = mem_addr[15:0] - `CRF_AREA_LO;
    b_addr = ram_off[10:1];
    b_be = 2'b00;
    if (mem_req && !st_r.locked && mem_we && in_area && !is_sfr) begin
      b_be = ram_off[0] ? 2'b10 : 2'b01;
    end
  end

  crf_ram #(
    .AW(`CRF_RAM_AW)
  ) u_ram (
    .clk(mclk),
    .a_be(a_be),
    .a_addr(a_addr),
    .a_wdata(a_wdata),
    .a_rdata(a_rdata),
    .b_be(b_be),
    .b_addr(b_addr),
    .b_wdata({mem_wdata, mem_wdata}),
    .b_rdata(b_rdata)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.reg_ack = reg_ok;
    st_nxt.reg_err = reg_req && !st_r.locked && !reg_ok;
    st_nxt.rsize = reg_size;
    st_nxt.rhi = rbyte[0];
    st_nxt.ext_rd = st_r.ext[{st_r.bank, reg_idx[1:0]}];
    if (reg_ok && reg_we && reg_size == crf_pkg::CRF_SZ_A24) begin
      st_nxt.ext[{st_r.bank, reg_idx[1:0]}] = reg_wdata[23:16];
    end
    st_nxt.mem_ack = mem_req && !st_r.locked;
    st_nxt.mem_hi = ram_off[0];
    st_nxt.mem_int = in_area;
    st_nxt.mem_sfr = is_sfr;
    st_nxt.mem_ram = in_area && !is_sfr;
    if (!st_r.locked) begin
      if (reloc_valid && !st_r.reloc_done) begin
        if (data_area_relocate_op == `CRF_RELOC_LOW) begin
          st_nxt.area_hi = `CRF_RELOC_LOW;
          st_nxt.reloc_done = 1'b1;
        end else if (data_area_relocate_op == `CRF_RELOC_HIGH) begin
          st_nxt.area_hi = `CRF_RELOC_HIGH;
          st_nxt.reloc_done = 1'b1;
        end
      end
      if (ctx_switch_valid) begin
        st_nxt.bank = ctx_bank;
      end else if (bank_sel_valid) begin
        st_nxt.bank = bank_sel;
      end
      if (pc_load) begin
        st_nxt.pc = pc_load_val;
      end else begin
        st_nxt.pc = st_r.pc + `CRF_ADDR_W'(pc_step);
      end
      if (mem_req && is_sfr && !SFR_MAP[mem_addr[7:0]]) begin
        st_nxt.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.area_hi <= `CRF_AREA_HI_RST;
      st_r.pc <= `CRF_PC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    case (st_r.rsize)
      crf_pkg::CRF_SZ_B8: begin
        reg_rdata = {16'h0000, st_r.rhi ? a_rdata[15:8] : a_rdata[7:0]};
      end
      crf_pkg::CRF_SZ_W16: reg_rdata = {8'h00, a_rdata};
      crf_pkg::CRF_SZ_A24: reg_rdata = {st_r.ext_rd, a_rdata};
      default: reg_rdata = 24'h000000;
    endcase
    if (st_r.mem_ram) begin
      mem_rdata = st_r.mem_hi ? b_rdata[15:8] : b_rdata[7:0];
    end else begin
      mem_rdata = 8'h00;
    end
  end

  assign reg_ack = st_r.reg_ack;
  assign reg_err = st_r.reg_err;
  assign mem_ack = st_r.mem_ack;
  assign mem_int_hit = st_r.mem_int;
  assign mem_sfr_hit = st_r.mem_sfr;
  assign pc = st_r.pc;
  assign active_bank = st_r.bank;
  assign area_high = st_r.area_hi;
  assign reloc_done = st_r.reloc_done;
  assign core_locked = st_r.locked;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_reloc_once;
    @(posedge mclk) disable iff (rst)
    reloc_done && reloc_valid |=> $stable(area_high);
  endproperty
  a_reloc_once: assert property (p_reloc_once)
    else $error("data area moved after relocation");

  property p_reloc_low;
    @(posedge mclk) disable iff (rst)
    reloc_valid && !reloc_done && !core_locked &&
      data_area_relocate_op == 4'h0 |=> area_high == 4'h0 && reloc_done;
  endproperty
  a_reloc_low: assert property (p_reloc_low)
    else $error("low relocation not applied");

  property p_reloc_high;
    @(posedge mclk) disable iff (rst)
    reloc_valid && !reloc_done && !core_locked &&
      data_area_relocate_op == 4'hf |=> area_high == 4'hf && reloc_done;
  endproperty
  a_reloc_high: assert property (p_reloc_high)
    else $error("high relocation not applied");

  property p_int_hit;
    @(posedge mclk) disable iff (rst)
    mem_req && !core_locked && mem_addr[19:16] == area_high &&
      mem_addr[15:0] >= 16'hf700 |=> mem_ack && mem_int_hit;
  endproperty
  a_int_hit: assert property (p_int_hit)
    else $error("data area address not decoded");

  property p_w16_roundtrip;
    @(posedge mclk) disable iff (rst)
    (reg_req && reg_we && reg_size == crf_pkg::CRF_SZ_W16 && !reg_legacy &&
      !core_locked && !mem_req && !bank_sel_valid && !ctx_switch_valid) ##1
    (reg_req && !reg_we && reg_size == crf_pkg::CRF_SZ_W16 && !reg_legacy &&
      reg_idx[2:0] == $past(reg_idx[2:0]) && !core_locked)
    |=> reg_ack && reg_rdata[15:0] == $past(reg_wdata[15:0], 2);
  endproperty
  a_w16_roundtrip: assert property (p_w16_roundtrip)
    else $error("register pair lost its value");

  property p_ctx_bank;
    @(posedge mclk) disable iff (rst)
    ctx_switch_valid && !core_locked |=> active_bank == $past(ctx_bank);
  endproperty
  a_ctx_bank: assert property (p_ctx_bank)
    else $error("context switch bank not taken");

  property p_pc_step;
    @(posedge mclk) disable iff (rst)
    !core_locked && !pc_load |=>
      pc == $past(pc) + 20'($past(pc_step));
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter step wrong");

  property p_lock_sticky;
    @(posedge mclk) disable iff (rst)
    core_locked |=> core_locked && !reg_ack && !mem_ack;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock released or core still answering");

  property p_legacy_refused;
    @(posedge mclk) disable iff (rst)
    reg_req && reg_legacy && !processor_status_word[5] && !core_locked
      |=> reg_err && !reg_ack;
  endproperty
  a_legacy_refused: assert property (p_legacy_refused)
    else $error("legacy name accepted with alias off");

  c_reloc_high: cover property (@(posedge mclk) disable iff (rst)
    reloc_valid && data_area_relocate_op == 4'hf && !reloc_done);
  c_lock: cover property (@(posedge mclk) disable iff (rst)
    !core_locked ##1 core_locked);
  c_a24: cover property (@(posedge mclk) disable iff (rst)
    reg_ack && reg_rdata[23:16] != 8'h00);
endmodule // crf_core

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ------------------------------------------------------------
  // Signals and design
  // ------------------------------------------------------------
  localparam crf_pkg::crf_size_t B8 = crf_pkg::CRF_SZ_B8;
  localparam crf_pkg::crf_size_t W16 = crf_pkg::CRF_SZ_W16;
  localparam crf_pkg::crf_size_t A24 = crf_pkg::CRF_SZ_A24;
  logic mclk, rst, reloc_valid, bank_sel_valid, ctx_switch_valid;
  logic [3:0] data_area_relocate_op, reg_idx, area_high;
  logic [2:0] bank_sel, ctx_bank, pc_step, active_bank;
  logic [15:0] processor_status_word;
  logic reg_req, reg_we, reg_legacy, reg_ack, reg_err;
  crf_pkg::crf_size_t reg_size;
  logic [23:0] reg_wdata, reg_rdata, v, w;
  logic mem_req, mem_we, mem_ack, mem_int_hit, mem_sfr_hit, pc_load;
  logic [19:0] mem_addr, pc_load_val, pc, p0;
  logic [7:0] mem_wdata, mem_rdata;
  logic reloc_done, core_locked;
  logic [31:0] seed;
  logic [25:0] rq_q[$];
  logic [10:0] mq_q[$];
  logic [25:0] re;
  logic [10:0] me;
  int mismatches, n_checks;

  crf_core u_crf_core (.mclk, .rst, .reloc_valid, .data_area_relocate_op,
    .bank_sel_valid, .bank_sel, .ctx_switch_valid, .ctx_bank,
    .processor_status_word, .reg_req, .reg_we, .reg_size, .reg_legacy,
    .reg_idx, .reg_wdata, .reg_ack, .reg_err, .reg_rdata, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_int_hit,
    .mem_sfr_hit, .pc_load, .pc_load_val, .pc_step, .pc, .active_bank,
    .area_high, .reloc_done, .core_locked);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rq(logic we, crf_pkg::crf_size_t sz, logic lg,
                    logic [3:0] ix, logic [23:0] wd, logic [25:0] e);
    reg_req = 1'b1;
    reg_we = we;
    reg_size = sz;
    reg_legacy = lg;
    reg_idx = ix;
    reg_wdata = wd;
    rq_q.push_back(e);
    @(posedge mclk);
    #1;
  endtask

  task automatic mq(logic we, logic [19:0] a, logic [7:0] wd,
                    logic [10:0] e);
    mem_req = 1'b1;
    mem_we = we;
    mem_addr = a;
    mem_wdata = wd;
    mq_q.push_back(e);
    @(posedge mclk);
    #1;
  endtask

  task automatic idl();
    reg_req = 1'b0;
    mem_req = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rl(logic [3:0] op);
    reloc_valid = 1'b1;
    data_area_relocate_op = op;
    @(posedge mclk);
    #1;
    reloc_valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  always @(negedge mclk) begin
    if (reg_ack === 1'b1 || reg_err === 1'b1) begin
      if (rq_q.size() == 0) chk("reg_answer", 1, 0);
      else begin
        re = rq_q.pop_front();
        chk("reg_err", reg_err, re[24]);
        if (re[25]) chk("reg_rdata", reg_rdata, re[23:0]);
      end
    end
    if (mem_ack === 1'b1) begin
      if (mq_q.size() == 0) chk("mem_answer", 1, 0);
      else begin
        me = mq_q.pop_front();
        chk("mem_int_hit", mem_int_hit, me[9]);
        chk("mem_sfr_hit", mem_sfr_hit, me[8]);
        if (me[10]) chk("mem_rdata", mem_rdata, me[7:0]);
      end
    end
  end

  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reloc_valid, bank_sel_valid, ctx_switch_valid, pc_load} = 4'h0;
    {data_area_relocate_op, bank_sel, ctx_bank, pc_step} = 13'h0;
    {reg_req, reg_we, reg_legacy, reg_idx, reg_wdata} = 31'h0;
    {mem_req, mem_we, mem_addr, mem_wdata, pc_load_val} = 50'h0;
    processor_status_word = 16'h0000;
    reg_size = B8;
    seed = 32'h5e746208;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    chk("area_high", area_high, 0);
    chk("reloc_done", reloc_done, 0);
    chk("pc", pc, 0);
    for (int i = 0; i < 3; i++) begin
      v = 24'(rnd());
      pc_load_val = v[19:0];
      pc_load = 1'b1;
      @(posedge mclk);
      #1 pc_load = 1'b0;
      pc_step = v[22:20];
      p0 = pc_load_val + 20'(9 * v[22:20]);
      repeat (9) @(posedge mclk);
      #1 chk("pc", pc, p0);
    end
    pc_step = 3'h0;
    v = 24'(rnd());
    rq(1'b1, W16, 1'b0, 4'h3, v, 26'h0);
    rq(1'b0, W16, 1'b0, 4'h3, 24'h0, {10'h200, v[15:0]});
    rq(1'b0, B8, 1'b0, 4'h7, 24'h0, {18'h20000, v[15:8]});
    rq(1'b0, B8, 1'b0, 4'h6, 24'h0, {18'h20000, v[7:0]});
    idl();
    mq(1'b0, 20'h0fe87, 8'h0, {3'b110, v[15:8]});
    mq(1'b1, 20'h0fe80, v[23:16], 11'h200);
    mq(1'b0, 20'h0f6ff, 8'h0, 11'h400);
    idl();
    rq(1'b0, B8, 1'b0, 4'h0, 24'h0, {18'h20000, v[23:16]});
    w = 24'(rnd());
    rq(1'b1, A24, 1'b0, 4'h2, w, 26'h0);
    rq(1'b0, A24, 1'b0, 4'h2, 24'h0, {2'b10, w});
    rq(1'b0, W16, 1'b0, 4'h6, 24'h0, {10'h200, w[15:0]});
    rq(1'b0, B8, 1'b1, 4'h0, 24'h0, 26'h1000000);
    idl();
    processor_status_word = w[15:0] | 16'h0020;
    rq(1'b1, B8, 1'b0, 4'h5, v, 26'h0);
    rq(1'b0, B8, 1'b1, 4'h1, 24'h0, {18'h20000, v[7:0]});
    rq(1'b1, W16, 1'b1, 4'h0, w, 26'h0);
    rq(1'b0, W16, 1'b0, 4'h2, 24'h0, {10'h200, w[15:0]});
    rq(1'b0, A24, 1'b1, 4'h0, 24'h0, 26'h1000000);
    idl();
    {bank_sel_valid, bank_sel, ctx_switch_valid, ctx_bank} = 8'had;
    @(posedge mclk);
    #1 {bank_sel_valid, ctx_switch_valid} = 2'b00;
    chk("active_bank", active_bank, 5);
    v = 24'(rnd());
    rq(1'b1, B8, 1'b0, 4'h0, v, 26'h0);
    idl();
    mq(1'b0, 20'h0fed0, 8'h0, {3'b110, v[7:0]});
    idl();
    {bank_sel_valid, bank_sel} = 4'ha;
    @(posedge mclk);
    #1 bank_sel_valid = 1'b0;
    chk("active_bank", active_bank, 2);
    rl(4'h5);
    chk("reloc_done", reloc_done, 0);
    rl(4'hf);
    chk("area_high", area_high, 4'hf);
    chk("reloc_done", reloc_done, 1);
    rl(4'h0);
    chk("area_high", area_high, 4'hf);
    mq(1'b0, 20'hffed0, 8'h0, {3'b110, v[7:0]});
    mq(1'b0, 20'h0fed0, 8'h0, 11'h400);
    mq(1'b0, 20'hfff00, 8'h0, 11'h700);
    pc_step = 3'h3;
    mq(1'b0, 20'hfff04, 8'h0, 11'h700);
    idl();
    chk("core_locked", core_locked, 1);
    p0 = pc;
    {reg_req, mem_req} = 2'b11;
    rl(4'h0);
    idl();
    chk("pc", pc, p0);
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    chk("core_locked", core_locked, 0);
    chk("area_high", area_high, 0);
    chk("reloc_done", reloc_done, 0);
    chk("active_bank", active_bank, 0);
    chk("pc", pc, 0);
    rl(4'h0);
    chk("reloc_done", reloc_done, 1);
    chk("area_high", area_high, 0);
    rl(4'hf);
    chk("area_high", area_high, 0);
    mq(1'b0, 20'h0fed0, 8'h0, {3'b110, v[7:0]});
    mq(1'b0, 20'hffed0, 8'h0, 11'h400);
    idl();
    repeat (3) @(posedge mclk);
    chk("pending", rq_q.size() + mq_q.size(), 0);
    give_verdict();
  end
endmodule // tb_top
